//--- core/tpr_map.vh
// Register map, field positions and reset values of the timer prescaler core
`ifndef TPR_MAP_VH
`define TPR_MAP_VH

`define TPR_OFS_CONTROL_A   8'h00
`define TPR_OFS_DEBUG_HALT  8'h04
`define TPR_OFS_COUNT       8'h08
`define TPR_OFS_PERIOD      8'h0C
`define TPR_OFS_STATUS      8'h10

`define TPR_CA_SOFT_RESET_BIT        0
`define TPR_CA_ENABLE       1
`define TPR_CA_RES_LO       2
`define TPR_CA_RES_HI       3
`define TPR_CA_EVCOUNT      4
`define TPR_CA_PRESC_LO     8
`define TPR_CA_PRESC_HI     10
`define TPR_CA_DIVIDER_SYNC_SELECT      12

`define TPR_RES_16          2'h0
`define TPR_RES_8           2'h1
`define TPR_RES_32          2'h2

`define TPR_SYNC_CLOCK      1'b0
`define TPR_SYNC_TICK       1'b1

`define TPR_DIV1            10'h001
`define TPR_DIV2            10'h002
`define TPR_DIV4            10'h004
`define TPR_DIV8            10'h008
`define TPR_DIV16           10'h010
`define TPR_DIV64           10'h040
`define TPR_DIV256          10'h100
`define TPR_DIV1024         10'h400

`define TPR_RST_PERIOD      8'hFF
`define TPR_HALF_TOP        16'hFFFF

`endif

//--- core/tpr_sync_edge.v
// Two-stage pin synchroniser with rising-edge pulse
`timescale 1ns/10ps
`default_nettype none
module tpr_sync_edge (
  input  wire clk_in,
  input  wire rst_in,
  input  wire pin_in,
  output reg  level_out,
  output reg  rise_out
);
  reg meta_r;
  reg last_r;

  always @(posedge clk_in) begin
    if (rst_in) begin
      meta_r    <= 1'b0;
      level_out <= 1'b0;
      last_r    <= 1'b0;
      rise_out  <= 1'b0;
    end else begin
      meta_r    <= pin_in;
      level_out <= meta_r;
      last_r    <= level_out;
      rise_out  <= level_out & ~last_r;
    end
  end
endmodule // tpr_sync_edge
`default_nettype wire

//--- core/tpr_prescaler.v
// Clock prescaler: divides the source clock into ticks and a toggling output
`timescale 1ns/10ps
`default_nettype none
`include "tpr_map.vh"
module tpr_prescaler (
  input  wire       clk_in,
  input  wire       rst_in,
  input  wire       run_in,
  input  wire [2:0] sel_in,
  output reg        tick_out,
  output reg        toggle_out,
  output wire       div_one_out
);
  reg  [9:0] cnt_r;
  reg  [9:0] div_w;

  always @* begin
    case (sel_in)
      3'h0:    div_w = `TPR_DIV1;
      3'h1:    div_w = `TPR_DIV2;
      3'h2:    div_w = `TPR_DIV4;
      3'h3:    div_w = `TPR_DIV8;
      3'h4:    div_w = `TPR_DIV16;
      3'h5:    div_w = `TPR_DIV64;
      3'h6:    div_w = `TPR_DIV256;
      default: div_w = `TPR_DIV1024;
    endcase
  end

  assign div_one_out = (div_w == `TPR_DIV1);

  // Counts to the division value, then ticks and toggles
  always @(posedge clk_in) begin
    if (rst_in || !run_in) begin
      cnt_r      <= 10'h000;
      tick_out   <= 1'b0;
      toggle_out <= 1'b0;
    end else if (cnt_r >= div_w - 10'h001) begin
      cnt_r      <= 10'h000;
      tick_out   <= 1'b1;
      toggle_out <= ~toggle_out;
    end else begin
      cnt_r      <= cnt_r + 10'h001;
      tick_out   <= 1'b0;
    end
  end
endmodule // tpr_prescaler
`default_nettype wire

//--- core/tpr_timer.v
// Timer unit core: AHB-Lite registers, prescaler, event counting, 8/16/32-bit counter
//
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "tpr_map.vh"
module tpr_timer #(
  parameter [3:0] UNIT_ID = 4'h3
) (
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire        hsel_in,
  input  wire [31:0] haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire [31:0] hwdata_in,
  input  wire        hready_in,
  output reg  [31:0] hrdata_out,
  output reg         hreadyout_out,
  output reg         hresp_out,
  input  wire        event_in,
  input  wire        debug_halt_in,
  output reg  [31:0] count_out,
  output reg         count_tick_out,
  output reg         top_out,
  output reg         presc_wave_out,
  output reg         enabled_out
);
  // Only units 3 and 5 may run 32 bits wide
  localparam [0:0] PAIR_OK = (UNIT_ID == 4'h3) || (UNIT_ID == 4'h5);

  // Bus engine states
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RDWT = 2'b10;

  // Control state
  reg        enable_r;
  reg [1:0]  res_r;
  reg        evcount_r;
  reg [2:0]  presc_r;
  reg        divider_sync_select_r;
  reg [7:0]  period_r;
  reg        dbg_run_r;
  reg        load_pend_r;
  reg [31:0] load_val_r;

  // Bus state
  reg [1:0]  st_r;
  reg        wr_pend_r;
  reg        rd_pend_r;
  reg [7:0]  addr_r;

  // Counter halves
  reg [15:0] half_r [0:1];

  wire       ev_level;
  wire       ev_rise;
  wire       dbg_level;
  wire       presc_tick;
  wire       presc_wave;
  wire       div_one;

  // Resolution decode
  wire mode8  = (res_r == `TPR_RES_8);
  wire mode32 = (res_r == `TPR_RES_32) && PAIR_OK;
  wire mode16 = !mode8 && !mode32;

  // Address phase
  wire addr_ok  = hsel_in && htrans_in[1] && hready_in;
  wire addr_wr  = addr_ok && hwrite_in;
  wire addr_rd  = addr_ok && !hwrite_in;

  // Register select decode of the latched data-phase address
  reg        sel_ctrl;
  reg        sel_dbg;
  reg        sel_cnt;
  reg        sel_per;
  reg        sel_stat;
  always @* begin
    sel_ctrl = 1'b0;
    sel_dbg  = 1'b0;
    sel_cnt  = 1'b0;
    sel_per  = 1'b0;
    sel_stat = 1'b0;
    case (addr_r)
      `TPR_OFS_CONTROL_A: begin
        sel_ctrl = 1'b1;
      end
      `TPR_OFS_DEBUG_HALT: begin
        sel_dbg = 1'b1;
      end
      `TPR_OFS_COUNT: begin
        sel_cnt = 1'b1;
      end
      `TPR_OFS_PERIOD: begin
        sel_per = 1'b1;
      end
      `TPR_OFS_STATUS: begin
        sel_stat = 1'b1;
      end
      default: begin
        sel_ctrl = 1'b0;
        sel_dbg  = 1'b0;
        sel_cnt  = 1'b0;
        sel_per  = 1'b0;
        sel_stat = 1'b0;
      end
    endcase
  end

  // Data phase write strobes
  wire wr_ctrl  = wr_pend_r && sel_ctrl;
  wire wr_dbg   = wr_pend_r && sel_dbg;
  wire wr_cnt   = wr_pend_r && sel_cnt;
  wire wr_per   = wr_pend_r && sel_per;
  wire soft_reset_bit    = wr_ctrl && hwdata_in[`TPR_CA_SOFT_RESET_BIT];

  // Counting is paused while the debugger halts, unless told to run on
  wire halted   = dbg_level && !dbg_run_r;
  wire run      = enable_r && !halted;

  // Event ticks bypass the prescaler
  wire tick     = run && (evcount_r ? ev_rise : presc_tick);

  // Prescaler is held cleared while idle, in event mode or by soft reset
  wire presc_rst = rst_in || soft_reset_bit;
  wire presc_run = run && !evcount_r;

  // Pending count loads land at once or on the next prescaled tick
  wire load_now = load_pend_r && (evcount_r || div_one ||
                  divider_sync_select_r == `TPR_SYNC_CLOCK || !enable_r ||
                  presc_tick);

  wire at_top8  = (half_r[0][7:0] == period_r);
  wire at_top16 = (half_r[0] == `TPR_HALF_TOP);
  wire at_top32 = at_top16 && (half_r[1] == `TPR_HALF_TOP);
  wire at_top   = mode8 ? at_top8 : (mode32 ? at_top32 : at_top16);

  tpr_sync_edge u_event_sync (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .pin_in    (event_in),
    .level_out (ev_level),
    .rise_out  (ev_rise)
  );

  tpr_sync_edge u_debug_sync (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .pin_in    (debug_halt_in),
    .level_out (dbg_level),
    .rise_out  ()
  );

  tpr_prescaler u_presc (
    .clk_in      (clk_in),
    .rst_in      (presc_rst),
    .run_in      (presc_run),
    .sel_in      (presc_r),
    .tick_out    (presc_tick),
    .toggle_out  (presc_wave),
    .div_one_out (div_one)
  );

  // Control register A, period and pending load
  always @(posedge clk_in) begin
    if (rst_in || soft_reset_bit) begin
      enable_r    <= 1'b0;
      res_r       <= `TPR_RES_16;
      evcount_r   <= 1'b0;
      presc_r     <= 3'h0;
      divider_sync_select_r   <= `TPR_SYNC_CLOCK;
      period_r    <= `TPR_RST_PERIOD;
      load_pend_r <= 1'b0;
      load_val_r  <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) begin
        enable_r  <= hwdata_in[`TPR_CA_ENABLE];
        res_r     <= hwdata_in[`TPR_CA_RES_HI:`TPR_CA_RES_LO];
        evcount_r <= hwdata_in[`TPR_CA_EVCOUNT];
        presc_r   <= hwdata_in[`TPR_CA_PRESC_HI:`TPR_CA_PRESC_LO];
        divider_sync_select_r <= hwdata_in[`TPR_CA_DIVIDER_SYNC_SELECT];
      end
      if (wr_per && mode8) begin
        period_r <= hwdata_in[7:0];
      end
      if (wr_cnt) begin
        load_pend_r <= 1'b1;
        load_val_r  <= hwdata_in;
      end else if (load_now) begin
        load_pend_r <= 1'b0;
      end
    end
  end

  // Debug halt control survives a soft reset
  always @(posedge clk_in) begin
    if (rst_in) begin
      dbg_run_r <= 1'b0;
    end else if (wr_dbg) begin
      dbg_run_r <= hwdata_in[0];
    end
  end

  // Counter: low half counts every tick, high half takes the carry in 32-bit mode
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_half
      reg [15:0] half_nxt;
      always @* begin
        half_nxt = half_r[g];
        if (load_now) begin
          if (g == 0) begin
            half_nxt = mode8 ? {8'h00, load_val_r[7:0]} : load_val_r[15:0];
          end else begin
            half_nxt = mode32 ? load_val_r[31:16] : 16'h0000;
          end
        end else if (tick) begin
          if (g == 0) begin
            if (mode8) begin
              half_nxt = at_top8 ? 16'h0000 : {8'h00, half_r[0][7:0] + 8'h01};
            end else begin
              half_nxt = half_r[0] + 16'h0001;
            end
          end else if (mode32 && at_top16) begin
            half_nxt = half_r[1] + 16'h0001;
          end
        end
      end
      always @(posedge clk_in) begin
        if (rst_in || soft_reset_bit) begin
          half_r[g] <= 16'h0000;
        end else begin
          half_r[g] <= half_nxt;
        end
      end
    end
  endgenerate

  // Registered user-side outputs
  always @(posedge clk_in) begin
    if (rst_in || soft_reset_bit) begin
      count_out      <= 32'h0000_0000;
      count_tick_out <= 1'b0;
      top_out        <= 1'b0;
      presc_wave_out <= 1'b0;
      enabled_out    <= 1'b0;
    end else begin
      count_out      <= {half_r[1], half_r[0]};
      count_tick_out <= tick;
      top_out        <= tick && at_top && !load_now;
      presc_wave_out <= presc_wave;
      enabled_out    <= enable_r;
    end
  end

  // Read data mux, value sampled in the wait cycle of a read
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    // Selects are one-hot, so the first true item is the only one
    case (1'b1)
      sel_ctrl: begin
        rd_mux[`TPR_CA_ENABLE]                   = enable_r;
        rd_mux[`TPR_CA_RES_HI:`TPR_CA_RES_LO]    = res_r;
        rd_mux[`TPR_CA_EVCOUNT]                  = evcount_r;
        rd_mux[`TPR_CA_PRESC_HI:`TPR_CA_PRESC_LO] = presc_r;
        rd_mux[`TPR_CA_DIVIDER_SYNC_SELECT]                  = divider_sync_select_r;
      end
      sel_dbg: begin
        rd_mux[0] = dbg_run_r;
      end
      sel_cnt: begin
        if (mode8) begin
          rd_mux[7:0] = half_r[0][7:0];
        end else if (mode32) begin
          rd_mux = {half_r[1], half_r[0]};
        end else begin
          rd_mux[15:0] = half_r[0];
        end
      end
      sel_per: begin
        if (mode8) begin
          rd_mux[7:0] = period_r;
        end
      end
      sel_stat: begin
        rd_mux[0] = run;
        rd_mux[1] = halted;
        rd_mux[2] = load_pend_r;
        rd_mux[3] = mode32;
        rd_mux[4] = ev_level;
        rd_mux[5] = PAIR_OK;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // AHB-Lite slave: writes with no wait, reads with one wait state
  always @(posedge clk_in) begin
    if (rst_in) begin
      st_r          <= ST_IDLE;
      wr_pend_r     <= 1'b0;
      rd_pend_r     <= 1'b0;
      addr_r        <= 8'h00;
      hrdata_out    <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else begin
      hresp_out <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          wr_pend_r <= addr_wr;
          rd_pend_r <= addr_rd;
          if (addr_ok) begin
            addr_r <= {haddr_in[7:2], 2'b00};
          end
          if (addr_rd) begin
            hreadyout_out <= 1'b0;
            st_r          <= ST_RDWT;
          end
        end
        ST_RDWT: begin
          wr_pend_r     <= 1'b0;
          rd_pend_r     <= 1'b0;
          hrdata_out    <= rd_mux;
          hreadyout_out <= 1'b1;
          st_r          <= ST_IDLE;
        end
        default: begin
          wr_pend_r     <= 1'b0;
          rd_pend_r     <= 1'b0;
          hreadyout_out <= 1'b1;
          st_r          <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // tpr_timer
`default_nettype wire

//--- verif/tpr_timer_asserts.sv
// Port checks for the timer core
`timescale 1ns/10ps
`default_nettype none
module tpr_timer_asserts (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic        hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  input wire logic        count_tick_out,
  input wire logic        top_out,
  input wire logic        enabled_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire  req = hsel_in & htrans_in[1] & hready_in;
  logic ctl_r, done_r, en_r;
  // Expected enable level after each control_a write
  always @(posedge clk_in) begin
    ctl_r  <= !rst_in & req & hwrite_in & (haddr_in[7:2] == 6'h0);
    done_r <= ctl_r;
    if (ctl_r) en_r <= hwdata_in[1] & !hwdata_in[0];
  end
  a_resp_okay: assert property (hresp_out == 1'b0) else $error("bus error response");
  a_read_wait: assert property (req && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
    else $error("read wait state wrong");
  a_write_ready: assert property (req && hwrite_in |=> hreadyout_out) else $error("write stall");
  a_wait_once: assert property (!hreadyout_out |=> hreadyout_out) else $error("wait too long");
  a_rdata_hold: assert property (!$rose(hreadyout_out) |-> $stable(hrdata_out))
    else $error("read data moved");
  a_enable_write: assert property (done_r |-> ##[0:1] enabled_out == en_r)
    else $error("enable not applied");
  a_tick_enabled: assert property (count_tick_out |-> enabled_out || $past(enabled_out))
    else $error("tick while disabled");
  a_top_on_tick: assert property (top_out |-> count_tick_out)
    else $error("top without tick");
  c_read: cover property (req && !hwrite_in);
  c_top: cover property (top_out);
  c_tick: cover property (count_tick_out ##1 count_tick_out);
endmodule // tpr_timer_asserts
bind tpr_timer tpr_timer_asserts u_chk (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel_in),
  .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in),
  .hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
  .hresp_out(hresp_out), .count_tick_out(count_tick_out), .top_out(top_out),
  .enabled_out(enabled_out));
`default_nettype wire

//--- verif/tpr_timer_prescaler_resolution_core_bench.sv
// Self-checking bench for the timer core
`timescale 1ns/10ps
`default_nettype none
`include "tpr_map.vh"
module timer_prescaler_resolution_core_bench;
  logic        clk_in, rst_in, hsel_in, hwrite_in, event_in;
  logic [31:0] haddr_in, hwdata_in, rdat;
  logic [1:0]  htrans_in;
  wire  [31:0] hrdata_out, count_out;
  wire         hreadyout_out, hresp_out, count_tick_out, top_out, presc_wave_out, enabled_out;
  integer      n_mismatch, compares, seed, cyc, n, v;
  integer      tq[$], cq[$], topq[$], wq[$];
  integer      divs[0:7] = '{1, 2, 4, 8, 16, 64, 256, 1024};
  tpr_timer #(.UNIT_ID(4'h3)) dut (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2),
    .hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .event_in(event_in),
    .debug_halt_in(1'b0), .count_out(count_out), .count_tick_out(count_tick_out),
    .top_out(top_out), .presc_wave_out(presc_wave_out), .enabled_out(enabled_out));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // Cycle stamps of tick and top pulses, with the count seen at each tick
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (count_tick_out === 1'b1) begin
      tq.push_back(cyc);
      cq.push_back(count_out);
      wq.push_back(presc_wave_out);
    end
    if (top_out === 1'b1) topq.push_back(cyc);
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task tmo;
    n_mismatch = n_mismatch + 1;
    $display("[ERR] %0t wait ran out", $time);
    tally_and_finish;
  endtask
  // Waits for hready, then lets the sampling edge pass
  task hs;
    integer k;
    k = 0;
    @(negedge clk_in);
    while (hreadyout_out !== 1'b1 && k < 20) begin
      k = k + 1;
      @(negedge clk_in);
    end
    if (k >= 20) tmo;
    rdat = hrdata_out;
    @(posedge clk_in);
  endtask
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    hsel_in   <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in  <= {24'h0000_00, a};
    hwrite_in <= wr;
    hs;
    hsel_in   <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= d;
    hs;
  endtask
  task wt(input integer m, input logic top);
    integer k;
    k = 0;
    while ((top ? topq.size() : tq.size()) < m && k < 4000) begin
      k = k + 1;
      @(negedge clk_in);
    end
    if (k >= 4000) tmo;
  endtask
  // Event counting with the slowest prescaler setting, which must not matter
  task evrun(input logic [31:0] res, input logic [31:0] ld, input integer m,
             input logic [31:0] msk);
    bus(1'b1, `TPR_OFS_CONTROL_A, res);
    bus(1'b1, `TPR_OFS_COUNT, ld);
    bus(1'b1, `TPR_OFS_CONTROL_A, res | 32'h0000_0712);
    repeat (m) begin
      repeat (3) @(posedge clk_in);
      event_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      event_in <= 1'b0;
    end
    repeat (10) @(posedge clk_in);
    bus(1'b1, `TPR_OFS_CONTROL_A, res);
    bus(1'b0, `TPR_OFS_COUNT, 32'h0);
    chk(rdat & msk, (ld + m) & msk);
  endtask
  initial begin
    seed = 32'h113c;
    n_mismatch = 0;
    compares = 0;
    cyc = 0;
    rst_in = 1'b1;
    hsel_in = 1'b0;
    haddr_in = 32'h0;
    htrans_in = 2'h0;
    hwrite_in = 1'b0;
    hwdata_in = 32'h0;
    event_in = 1'b0;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    bus(1'b0, `TPR_OFS_CONTROL_A, 32'h0);
    chk(rdat, 32'h0);
    bus(1'b1, `TPR_OFS_PERIOD, 32'h5);
    bus(1'b0, `TPR_OFS_PERIOD, 32'h0);
    chk(rdat, 32'h0);
    bus(1'b0, 8'h14, 32'h0);
    chk(rdat, 32'h0);
    for (n = 0; n < 8; n = n + 1) begin
      bus(1'b1, `TPR_OFS_CONTROL_A, (n << 8) | 2);
      repeat (2) @(negedge clk_in);
      chk({31'h0, enabled_out}, 32'h1);
      tq.delete();
      cq.delete();
      wq.delete();
      wt(3, 1'b0);
      chk(tq[2] - tq[1], divs[n]);
      chk((cq[2] - cq[1]) & 32'hFFFF, 32'h1);
      chk((wq[2] ^ wq[1]) & 1, 32'h1);
      bus(1'b1, `TPR_OFS_CONTROL_A, 32'h0);
      repeat (3) @(negedge clk_in);
      chk({31'h0, enabled_out}, 32'h0);
      tq.delete();
      v = count_out;
      repeat (20) @(negedge clk_in);
      chk(tq.size(), 0);
      chk(count_out, v);
    end
    v = 3 + ($random(seed) & 7);
    bus(1'b1, `TPR_OFS_CONTROL_A, 32'h4);
    bus(1'b1, `TPR_OFS_PERIOD, v);
    bus(1'b0, `TPR_OFS_PERIOD, 32'h0);
    chk(rdat, v);
    bus(1'b1, `TPR_OFS_CONTROL_A, 32'h6);
    @(negedge clk_in);
    topq.delete();
    wt(3, 1'b1);
    chk(topq[2] - topq[1], v + 1);
    bus(1'b1, `TPR_OFS_CONTROL_A, 32'h4);
    bus(1'b1, `TPR_OFS_DEBUG_HALT, 32'h1);
    bus(1'b1, `TPR_OFS_CONTROL_A, 32'h1);
    bus(1'b0, `TPR_OFS_CONTROL_A, 32'h0);
    chk(rdat, 32'h0);
    bus(1'b0, `TPR_OFS_COUNT, 32'h0);
    chk(rdat, 32'h0);
    bus(1'b0, `TPR_OFS_DEBUG_HALT, 32'h0);
    chk(rdat, 32'h1);
    bus(1'b1, `TPR_OFS_CONTROL_A, 32'h4);
    bus(1'b0, `TPR_OFS_PERIOD, 32'h0);
    chk(rdat, 32'hFF);
    evrun(32'h8, 32'h0000_FFFE, 3, 32'hFFFF_FFFF);
    v = 1 + ($random(seed) & 7);
    evrun(32'h0, $random(seed) & 32'hFFFF, v, 32'hFFFF);
    tally_and_finish;
  end
endmodule // timer_prescaler_resolution_core_bench
`default_nettype wire
